/* inc/supply_monitor_pkg.sv */
package supply_monitor_pkg;

    // Register offsets, as byte addresses on the plain register port.
    localparam logic [15:0] LEVEL_SEL_OFFSET = 16'h3F66;
    localparam logic [15:0] CTRL_STATUS_OFFSET = 16'h3F67;
    localparam logic [15:0] FILTER_CTRL_OFFSET = 16'h3F68;

    // Field positions.
    localparam int ENABLE_BIT = 0;
    localparam int ABOVE_BIT = 1;
    localparam int FILTER_EN_BIT = 0;
    localparam int SAMPLE_SEL_LSB = 1;
    localparam int LEVEL_LSB = 0;

    // Reset values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] FILTER_RESET = 8'h00;
    localparam logic [4:0] LEVEL_RESET = 5'h00;

    // Sample clock select codes.
    localparam logic [2:0] SEL_FAST = 3'h0;
    localparam logic [2:0] SEL_SLOW = 3'h7;
    localparam int FIRST_DIV_EXP = 5;
    localparam int DIV_BITS = 10;

    // Enable settling time that software must respect after enabling.
    localparam real SETTLE_MS = 1.5;
    localparam real CLK_MHZ = 125.0;
    localparam int SETTLE_CYCLES = int'(SETTLE_MS * 1000.0 * CLK_MHZ);

    // Register bus request carried as one group.
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    // Control fields held by the block.
    typedef struct packed {
        logic [4:0] level;
        logic enable;
        logic [2:0] sample_sel;
        logic filter_en;
    } ctrl_s;

endpackage

/* logic/supply_monitor_ctrl.sv */
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
// How it works
// - Bit 1 of the control/status register reads 1 when the supply is above the threshold, else 0.
// - Bit 0 of the control/status register enables detection when 1 and disables it when 0.
// - The above flag is not sticky; it follows the comparator and may change after an interrupt.
// - The filter control register inserts an optional noise filter and sets its sampling rate.
// - Sample select 000 is the fast clock, 001-110 divide it by 2^5-2^10, 111 is the slow clock.
// - Bit 0 of the filter control register bypasses the filter at 0 and inserts it at 1.
// - A rising crossing raises an interrupt that works with the CPU stopped.
// - Level code 01100 selects a 2.0 V threshold, passed straight to the reference.
// - While disabled, no interrupt is raised and the above flag holds its value.
// - While enabled, a falling crossing raises the interrupt and clears the flag.
// - While enabled, a rising crossing raises the interrupt and sets the flag.
module supply_monitor_ctrl
    import supply_monitor_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire reg_req_s req,
    output logic [7:0] rdata,
    input wire logic comp_above,
    input wire logic slow_clk_in,
    output logic detector_enable,
    output logic [4:0] threshold_level_sel,
    output logic supply_cross_irq
);

    // Returns one when the divider wraps for the selected power of two.
    function automatic logic div_tick(input logic [DIV_BITS-1:0] cnt, input logic [2:0] sel);
        logic [DIV_BITS-1:0] mask;
        mask = '0;
        for (int i = 0; i < DIV_BITS; i++)
        begin
            if (i < int'(sel) + FIRST_DIV_EXP - 1)
            begin
                mask[i] = 1'b1;
            end
        end
        div_tick = ((cnt & mask) == mask);
    endfunction

    // True when a request carries the given strobe for the given register offset.
    function automatic logic reg_hit(input logic strobe, input logic [15:0] addr,
        input logic [15:0] offset);
        reg_hit = strobe && (addr == offset);
    endfunction

    ctrl_s ctrl;
    ctrl_s next_ctrl;
    logic [1:0] comp_sync;
    logic [1:0] slow_sync;
    logic slow_prev;
    logic [DIV_BITS-1:0] div_cnt;
    logic [DIV_BITS-1:0] next_div_cnt;
    logic [1:0] samples;
    logic [1:0] next_samples;
    logic filt;
    logic next_filt;
    logic above;
    logic next_above;
    logic [7:0] next_rdata;
    logic next_irq;
    logic sample_en;
    logic level_in;
    logic [1:0] next_comp_sync;
    logic [1:0] next_slow_sync;
    logic next_slow_prev;

    // Shifts the comparator and the slow clock into two-stage synchronisers.
    // Only the second stage is read further on, which keeps metastability out of the logic.
    always_comb
    begin
        next_comp_sync = {comp_sync[0], comp_above};
        next_slow_sync = {slow_sync[0], slow_clk_in};
        next_slow_prev = slow_sync[1];
    end

    // Synchroniser registers for the comparator and the slow clock.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            comp_sync <= 2'h0;
            slow_sync <= 2'h0;
            slow_prev <= 1'b0;
        end
        else
        begin
            comp_sync <= next_comp_sync;
            slow_sync <= next_slow_sync;
            slow_prev <= next_slow_prev;
        end
    end

    // Register writes update the control fields.
    always_comb
    begin
        next_ctrl = ctrl;
        if (reg_hit(req.wr, req.addr, LEVEL_SEL_OFFSET))
        begin
            next_ctrl.level = req.wdata[LEVEL_LSB +: 5];
        end
        if (reg_hit(req.wr, req.addr, CTRL_STATUS_OFFSET))
        begin
            next_ctrl.enable = req.wdata[ENABLE_BIT];
        end
        if (reg_hit(req.wr, req.addr, FILTER_CTRL_OFFSET))
        begin
            next_ctrl.filter_en = req.wdata[FILTER_EN_BIT];
            next_ctrl.sample_sel = req.wdata[SAMPLE_SEL_LSB +: 3];
        end
    end

    // Sample enable from the selected clock source.
    always_comb
    begin
        next_div_cnt = div_cnt + 1'b1;
        case (ctrl.sample_sel)
            SEL_FAST: sample_en = 1'b1;
            SEL_SLOW: sample_en = slow_sync[1] & ~slow_prev;
            default: sample_en = div_tick(div_cnt, ctrl.sample_sel);
        endcase
    end

    // Two-sample noise filter and the unfiltered bypass.
    always_comb
    begin
        next_samples = samples;
        next_filt = filt;
        if (sample_en)
        begin
            next_samples = {samples[0], comp_sync[1]};
            if (next_samples[1] == next_samples[0])
            begin
                next_filt = next_samples[0];
            end
        end
        level_in = ctrl.filter_en ? filt : comp_sync[1];
    end

    // Flag tracking, crossing pulse and read data.
    // Enabling while the level already differs from the flag gives one pulse at once;
    // software keeps the interrupt masked through the settling time to hide it.
    always_comb
    begin
        next_above = above;
        next_irq = 1'b0;
        if (ctrl.enable && level_in != above)
        begin
            next_above = level_in;
            next_irq = 1'b1;
        end
        next_rdata = 8'h00;
        if (req.rd)
        begin
            case (req.addr)
                LEVEL_SEL_OFFSET: next_rdata = {3'h0, ctrl.level};
                CTRL_STATUS_OFFSET: next_rdata = {6'h00, above, ctrl.enable};
                FILTER_CTRL_OFFSET: next_rdata = {4'h0, ctrl.sample_sel, ctrl.filter_en};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Control fields and their copies towards the analogue side.
    // The copies load from the next values, so they never lag the stored fields.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl <= '{level: LEVEL_RESET, enable: CTRL_RESET[ENABLE_BIT],
                      sample_sel: FILTER_RESET[SAMPLE_SEL_LSB +: 3],
                      filter_en: FILTER_RESET[FILTER_EN_BIT]};
            detector_enable <= CTRL_RESET[ENABLE_BIT];
            threshold_level_sel <= LEVEL_RESET;
        end
        else
        begin
            ctrl <= next_ctrl;
            detector_enable <= next_ctrl.enable;
            threshold_level_sel <= next_ctrl.level;
        end
    end

    // Free-running divider that paces the slower sample rates.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            div_cnt <= '0;
        end
        else
        begin
            div_cnt <= next_div_cnt;
        end
    end

    // Filter sample history and the filtered level.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            samples <= 2'h0;
            filt <= 1'b0;
        end
        else
        begin
            samples <= next_samples;
            filt <= next_filt;
        end
    end

    // Monitor flag, crossing pulse and read data.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            above <= 1'b0;
            rdata <= 8'h00;
            supply_cross_irq <= 1'b0;
        end
        else
        begin
            above <= next_above;
            rdata <= next_rdata;
            supply_cross_irq <= next_irq;
        end
    end

endmodule

/* tb/supply_monitor_asserts.sv */
`timescale 1ns/1ps
// Watches the register port and the control outputs of the monitor.
module supply_monitor_asserts
    import supply_monitor_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire reg_req_s req,
    input wire logic [7:0] rdata,
    input wire logic detector_enable,
    input wire logic [4:0] threshold_level_sel,
    input wire logic supply_cross_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Register accesses as seen on the bus.
    sequence s_wr(a); req.wr && req.addr == a; endsequence
    sequence s_rd(a); req.rd && req.addr == a; endsequence
    // Read data, control copies and the interrupt tied to their causes.
    property p_idle; !req.rd |=> rdata == 8'h00; endproperty
    property p_en; s_wr(CTRL_STATUS_OFFSET) |=> detector_enable == $past(req.wdata[0]); endproperty
    property p_hold; !req.wr |=> $stable(detector_enable); endproperty
    property p_lvl; s_wr(LEVEL_SEL_OFFSET) |=> threshold_level_sel == $past(req.wdata[4:0]);
    endproperty
    property p_rd_ctrl; s_rd(CTRL_STATUS_OFFSET) |=> rdata[7:2] == 6'h00 &&
        rdata[0] == $past(detector_enable); endproperty
    property p_rd_filt; s_rd(FILTER_CTRL_OFFSET) |=> rdata[7:4] == 4'h0; endproperty
    property p_rd_lvl; s_rd(LEVEL_SEL_OFFSET) |=> rdata == {3'h0, $past(threshold_level_sel)};
    endproperty
    property p_off; !detector_enable && !$past(detector_enable) |-> !supply_cross_irq; endproperty
    a_idle: assert property (p_idle) else $error("stray read data");
    a_en: assert property (p_en) else $error("enable write lost");
    a_hold: assert property (p_hold) else $error("enable moved alone");
    a_lvl: assert property (p_lvl) else $error("level write lost");
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");
    a_rd_filt: assert property (p_rd_filt) else $error("filter read wrong");
    a_rd_lvl: assert property (p_rd_lvl) else $error("level read wrong");
    a_off: assert property (p_off) else $error("interrupt while off");
endmodule
bind supply_monitor_ctrl supply_monitor_asserts supply_monitor_asserts_inst (.clk(clk),
    .rst(rst), .req(req), .rdata(rdata), .detector_enable(detector_enable),
    .threshold_level_sel(threshold_level_sel), .supply_cross_irq(supply_cross_irq));

/* tb/supply_model.sv */
`timescale 1ns/1ps
module supply_model (
    input wire logic clk,
    input wire logic above_cmd,
    output logic comp_above,
    output logic slow_clk_in
);
    logic [1:0] div = 2'h0;
    // The comparator settles a little after the supply moves, off the clock edge.
    assign #3 comp_above = above_cmd;
    // The slow oscillator runs free at a quarter of the system clock.
    always @(posedge clk) div <= div + 2'h1;
    assign slow_clk_in = div[1];
endmodule

/* tb/test_supply_monitor_ctrl.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
    $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module test_supply_monitor_ctrl
    import supply_monitor_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, above_cmd = 1'b0, rd_d = 1'b0;
    // The model comparator settles 3 ns after the supply moves, so a short wait stands in for the settling time.
    localparam int SETTLE_WAIT = 64;
    logic comp_above, slow_clk_in, detector_enable, supply_cross_irq;
    logic [7:0] rdata, lvl, e;
    logic [4:0] threshold_level_sel;
    reg_req_s req = '0;
    logic [7:0] exp_q[$];
    int miscompares = 0, n_compared = 0, irqs = 0, seed = 32'hFE19, n;
    supply_monitor_ctrl supply_monitor_ctrl_inst (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
        .comp_above(comp_above), .slow_clk_in(slow_clk_in), .detector_enable(detector_enable),
        .threshold_level_sel(threshold_level_sel), .supply_cross_irq(supply_cross_irq));
    supply_model supply_model_inst (.clk(clk), .above_cmd(above_cmd), .comp_above(comp_above),
        .slow_clk_in(slow_clk_in));
    // Free-running system clock.
    initial
    begin
        forever #4 clk = ~clk;
    end
    // One register access; a read notes its expected data first.
    task automatic op(logic [15:0] a, logic [7:0] d, logic w, logic [7:0] x);
        if (!w) exp_q.push_back(x);
        @(posedge clk) req <= '{a, d, w, !w};
        @(posedge clk) req <= '0;
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Counts interrupt pulses and checks read data against the oldest note.
    always @(posedge clk)
    begin
        rd_d <= req.rd;
        if (supply_cross_irq === 1'b1) irqs++;
        if (!rst && $isunknown(supply_cross_irq))
        begin
            `CHK(supply_cross_irq, 1'b0)
        end
        if (rd_d === 1'b1)
        begin
            e = exp_q.pop_front();
            `CHK(rdata, e)
        end
    end
    // Cuts a hang short well past the longest filter wait.
    initial
    begin
        #400000;
        miscompares++;
        complete_run;
    end
    // Main sequence: registers, a crossing while off, then every sample rate.
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        op(CTRL_STATUS_OFFSET, 8'h00, 1'b0, CTRL_RESET);
        op(FILTER_CTRL_OFFSET, 8'h00, 1'b0, FILTER_RESET);
        op(16'h3F69, 8'h00, 1'b0, 8'h00);
        // Random level codes stay inside the range that software may use.
        repeat (3)
        begin
            lvl = 8'($unsigned($random(seed)) % 22);
            op(LEVEL_SEL_OFFSET, lvl, 1'b1, 8'h00);
            op(LEVEL_SEL_OFFSET, 8'h00, 1'b0, {3'h0, lvl[4:0]});
        end
        op(LEVEL_SEL_OFFSET, 8'h0C, 1'b1, 8'h00);
        @(negedge clk);
        `CHK(threshold_level_sel, 5'h0C)
        op(FILTER_CTRL_OFFSET, 8'hFF, 1'b1, 8'h00);
        op(FILTER_CTRL_OFFSET, 8'h00, 1'b0, 8'h0F);
        above_cmd <= 1'b1;
        repeat (30) @(posedge clk);
        op(CTRL_STATUS_OFFSET, 8'h00, 1'b0, 8'h00);
        `CHK(irqs, 0)
        above_cmd <= 1'b0;
        repeat (30) @(posedge clk);
        op(CTRL_STATUS_OFFSET, 8'h01, 1'b1, 8'h00);
        @(negedge clk);
        `CHK(detector_enable, 1'b1)
        repeat (SETTLE_WAIT) @(posedge clk);
        op(CTRL_STATUS_OFFSET, 8'h00, 1'b0, 8'h01);
        $display("register tests done");
        for (int k = 0; k < 9; k++)
        begin
            lvl = (k < 8) ? {4'h0, k[2:0], 1'b1} : 8'h00;
            op(FILTER_CTRL_OFFSET, lvl, 1'b1, 8'h00);
            above_cmd <= !above_cmd;
            n = irqs;
            for (int t = 0; t < 5000 && irqs == n; t++) @(posedge clk);
            repeat (40) @(posedge clk);
            `CHK(irqs, n + 1)
            op(CTRL_STATUS_OFFSET, 8'h00, 1'b0, {6'h00, above_cmd, 1'b1});
            $display("filter case %0d done", k);
        end
        // A crossing after detection is switched off again leaves the flag and the count alone.
        lvl = {6'h00, above_cmd, 1'b0};
        op(CTRL_STATUS_OFFSET, 8'h00, 1'b1, 8'h00);
        above_cmd <= !above_cmd;
        n = irqs;
        repeat (30) @(posedge clk);
        op(CTRL_STATUS_OFFSET, 8'h00, 1'b0, lvl);
        `CHK(irqs, n)
        $display("disable case done");
        complete_run;
    end
endmodule
